// File: pmt_pkg.sv
// Purpose: Shared constants for the 16-bit period match timer
// Assumes: System clock of 20 MHz, four system clocks per instruction cycle
// Notes:   Register indices are byte addresses on the plain register port
package pmt_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_CTL = 3'h0;
   localparam logic [2:0] ADDR_CNT_LO = 3'h1;
   localparam logic [2:0] ADDR_CNT_HI_BUF = 3'h2;
   localparam logic [2:0] ADDR_PER_LO = 3'h3;
   localparam logic [2:0] ADDR_PER_HI = 3'h4;
   localparam logic [2:0] ADDR_STATUS = 3'h5;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int CTL_RUN = 0;
   localparam int CTL_SRC = 1;
   localparam int CTL_BYPASS = 2;
   localparam int CTL_PS_LO = 3;
   localparam int CTL_PS_HI = 4;
   localparam int CTL_SINGLE = 5;
   localparam int CTL_TRIG_DIS = 6;
   localparam int CTL_SLEEP = 7;
   localparam int STAT_FLAG = 0;
   localparam logic [7:0] CTL_RESET = 8'h00;
   localparam logic [7:0] CTL_TRIG_DIS_MASK = 8'h40;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // ----------------------------------------------------------------
   // Counter and prescaler
   // ----------------------------------------------------------------
   typedef logic [15:0] pmt_count_t;
   localparam pmt_count_t COUNT_ZERO = 16'h0000;
   localparam pmt_count_t COUNT_MAX = 16'hFFFF;
   localparam pmt_count_t PERIOD_RESET = 16'hFFFF;
   localparam pmt_count_t COUNT_ONE = 16'h0001;
   localparam logic [2:0] PRESC_ZERO = 3'h0;
   localparam logic [2:0] PRESC_ONE = 3'h1;

   // ----------------------------------------------------------------
   // Instruction cycle phases
   // ----------------------------------------------------------------
   localparam int CLK_NS = 50;
   localparam int TCY_NS = 200;
   localparam int PHASES = TCY_NS / CLK_NS;
   localparam logic [1:0] PH_ONE = 2'h0;
   localparam logic [1:0] PH_TWO = 2'h1;
   localparam logic [1:0] PH_FOUR = PHASES[1:0] - 2'h1;
   localparam logic [2:0] RISE_PATTERN = 3'h3;

endpackage : pmt_pkg

// File: pmt_tick_if.sv
// Purpose: Count-event carrier from the input stage to the timer core
// Assumes: All signals live on the system clock
// Notes:   Each signal is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
interface pmt_tick_if;
   logic phase_one;
   logic sync_inc;
   logic async_rise;
   modport src (output phase_one, output sync_inc, output async_rise);
   modport snk (input phase_one, input sync_inc, input async_rise);
endinterface : pmt_tick_if
`default_nettype wire

// File: pmt_extin.sv
// Purpose: Quarter-phase generator and external count pin front end
// Assumes: Pin is asynchronous to the system clock
// Notes:   Async rise is still two-flop synchronised; there is no second clock
`timescale 1ns/10ps
`default_nettype none
module pmt_extin (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Pin
   input wire logic i_ext_count_pin,
   // Events
   pmt_tick_if.src o_tick
);

   logic [1:0] phase_r;
   logic pin_meta_r;
   logic pin_sync_r;
   logic pin_prev_r;
   logic [2:0] samp_r;
   logic pend_r;
   wire [1:0] phase_nxt = (phase_r == pmt_pkg::PH_FOUR) ? pmt_pkg::PH_ONE : phase_r + 2'h1;
   wire sample_en = (phase_r == pmt_pkg::PH_TWO) || (phase_r == pmt_pkg::PH_FOUR);
   wire [2:0] samp_nxt = {samp_r[1:0], pin_sync_r};
   wire rise_seen = sample_en && (samp_nxt == pmt_pkg::RISE_PATTERN);
   wire q1_next = (phase_nxt == pmt_pkg::PH_ONE);

   // ----------------------------------------------------------------
   // Phases and synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         phase_r <= pmt_pkg::PH_ONE;
         pin_meta_r <= 1'b0;
         pin_sync_r <= 1'b0;
         pin_prev_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
         pin_meta_r <= i_ext_count_pin;
         pin_sync_r <= pin_meta_r;
         pin_prev_r <= pin_sync_r;
      end
   end

   // ----------------------------------------------------------------
   // Sampling on phase two and four, increment on next phase one
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         samp_r <= 3'h0;
         pend_r <= 1'b0;
         o_tick.phase_one <= 1'b0;
         o_tick.sync_inc <= 1'b0;
         o_tick.async_rise <= 1'b0;
      end else begin
         if (sample_en) begin
            samp_r <= samp_nxt;
         end
         // A rise seen on phase four is spent at once, so it must not stay pending
         if (q1_next) begin
            pend_r <= 1'b0;
         end else if (rise_seen) begin
            pend_r <= 1'b1;
         end
         o_tick.phase_one <= q1_next;
         o_tick.sync_inc <= q1_next && (pend_r || rise_seen);
         o_tick.async_rise <= pin_sync_r && !pin_prev_r;
      end
   end

endmodule : pmt_extin
`default_nettype wire

// File: pmt_timer16.sv
// Purpose: 16-bit period match timer/counter with prescaler and trigger reset
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Notes on behaviour follow; trigger input is same-clock logic
//
// Notes on behaviour
// - Counter runs only while run_enable is set; clearing it halts counting.
// - sleep_run_enable set lets the timer run in sleep only as an unsynchronised external counter; clear stops it.
// - trigger_reset_disable set blocks the trigger reset; clear allows it.
// - Without the trigger option that bit reads zero and ignores writes.
// - single_shot_select one gives single-shot, zero continuous counting.
// - prescale_select 11/10/01/00 divides by 8/4/2/1.
// - External source: sync_bypass one counts unsynchronised, zero synchronised.
// - Internal source ignores sync_bypass and counts instruction cycles.
// - count_source_select one takes the pin, zero the instruction clock.
// - Count is two bytes; low byte direct, high byte via buffer.
// - Count equal to period resets count to zero and sets flag.
// - Timer configuration advances on phase one after prescaling.
// - Sync counter samples pin on phases two/four, rise over three samples.
// - Async counter counts pin rises through prescaler without phase alignment.
// - Disabling keeps the count; only counting, match, reset or write change it.
// - Period writes are accepted while running; software should avoid them.
// - Reset clears the whole control register.
// - Low byte read loads buffer; low byte write loads high from buffer.
// - Prescaler clears on count write, disable or reset, not control write.
// - Continuous: match or FFFFh rollover sets flag, clears count, keeps running.
// - Single-shot: match sets flag, clears count, hardware clears run_enable.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module pmt_timer16 #(
   parameter bit HAS_TRIG_DISABLE = 1'b1
) (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Register port
   input wire logic [2:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rd_data,
   // Pins and system
   input wire logic i_ext_count_pin,
   input wire logic i_sleep,
   input wire logic i_trig_reset,
   // Status
   output logic o_match_flag,
   output logic o_match_event,
   output logic o_run
);

   pmt_tick_if tick_bus ();

   pmt_extin u_extin (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_ext_count_pin(i_ext_count_pin),
      .o_tick(tick_bus.src)
   );

   logic [7:0] ctl_r;
   logic [7:0] ctl_nxt;
   pmt_pkg::pmt_count_t count_r;
   pmt_pkg::pmt_count_t count_nxt;
   pmt_pkg::pmt_count_t period_r;
   logic [7:0] hi_buf_r;
   logic [2:0] presc_r;
   logic flag_r;

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire wr_ctl = i_wr && (i_addr == pmt_pkg::ADDR_CTL);
   wire wr_lo = i_wr && (i_addr == pmt_pkg::ADDR_CNT_LO);
   wire wr_buf = i_wr && (i_addr == pmt_pkg::ADDR_CNT_HI_BUF);
   wire wr_plo = i_wr && (i_addr == pmt_pkg::ADDR_PER_LO);
   wire wr_phi = i_wr && (i_addr == pmt_pkg::ADDR_PER_HI);
   wire wr_stat = i_wr && (i_addr == pmt_pkg::ADDR_STATUS);
   wire rd_lo = i_rd && (i_addr == pmt_pkg::ADDR_CNT_LO);
   wire [7:0] ctl_wmask = HAS_TRIG_DISABLE ? 8'hFF : ~pmt_pkg::CTL_TRIG_DIS_MASK;

   wire run = ctl_r[pmt_pkg::CTL_RUN];
   wire src_ext = ctl_r[pmt_pkg::CTL_SRC];
   wire bypass = ctl_r[pmt_pkg::CTL_BYPASS];
   wire [1:0] ps_sel = ctl_r[pmt_pkg::CTL_PS_HI:pmt_pkg::CTL_PS_LO];
   wire single = ctl_r[pmt_pkg::CTL_SINGLE];
   wire trig_dis = ctl_r[pmt_pkg::CTL_TRIG_DIS];
   wire sleep_en = ctl_r[pmt_pkg::CTL_SLEEP];

   // ----------------------------------------------------------------
   // Count source, sleep gating and prescaler
   // ----------------------------------------------------------------
   // Internal source ignores the bypass bit entirely
   wire ext_tick = bypass ? tick_bus.async_rise : tick_bus.sync_inc;
   wire raw_tick = src_ext ? ext_tick : tick_bus.phase_one;
   // Sleep only lets the unsynchronised external path keep running
   wire sleep_ok = !i_sleep || (sleep_en && src_ext && bypass);
   wire active = run && sleep_ok;
   wire [2:0] presc_lim = (3'h1 << ps_sel) - 3'h1;
   // A smaller divide written mid-count ends the current group at the next tick
   wire presc_done = (presc_r >= presc_lim);
   wire count_tick = active && raw_tick && presc_done;
   wire [2:0] presc_nxt = presc_done ? pmt_pkg::PRESC_ZERO : presc_r + pmt_pkg::PRESC_ONE;

   // ----------------------------------------------------------------
   // Match and trigger reset
   // ----------------------------------------------------------------
   wire at_period = (count_r == period_r);
   wire at_max = (count_r == pmt_pkg::COUNT_MAX);
   wire match_hit = count_tick && (at_period || (at_max && !single));
   wire trig_hit = i_trig_reset && !trig_dis;
   wire trig_wake = trig_hit && single && !run;

   // A bus write to the count beats a simultaneous trigger reset
   always_comb begin
      count_nxt = count_r;
      if (wr_lo) begin
         count_nxt = {hi_buf_r, i_wr_data};
      end else if (trig_hit) begin
         count_nxt = pmt_pkg::COUNT_ZERO;
      end else if (match_hit) begin
         count_nxt = pmt_pkg::COUNT_ZERO;
      end else if (count_tick) begin
         count_nxt = count_r + pmt_pkg::COUNT_ONE;
      end
   end

   // A software write to the control register wins over hardware updates
   always_comb begin
      ctl_nxt = ctl_r;
      if (match_hit && single) begin
         ctl_nxt[pmt_pkg::CTL_RUN] = 1'b0;
      end
      if (trig_wake) begin
         ctl_nxt[pmt_pkg::CTL_RUN] = 1'b1;
      end
      if (wr_ctl) begin
         ctl_nxt = i_wr_data & ctl_wmask;
      end
   end

   wire flag_clr = wr_stat && i_wr_data[pmt_pkg::STAT_FLAG];
   wire flag_nxt = match_hit || (flag_r && !flag_clr);

   wire [7:0] rd_mux =
      (i_addr == pmt_pkg::ADDR_CTL) ? ctl_r :
      (i_addr == pmt_pkg::ADDR_CNT_LO) ? count_r[7:0] :
      (i_addr == pmt_pkg::ADDR_CNT_HI_BUF) ? hi_buf_r :
      (i_addr == pmt_pkg::ADDR_PER_LO) ? period_r[7:0] :
      (i_addr == pmt_pkg::ADDR_PER_HI) ? period_r[15:8] :
      (i_addr == pmt_pkg::ADDR_STATUS) ? {7'h00, flag_r} : pmt_pkg::BYTE_ZERO;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         ctl_r <= pmt_pkg::CTL_RESET;
         count_r <= pmt_pkg::COUNT_ZERO;
         flag_r <= 1'b0;
      end else begin
         ctl_r <= ctl_nxt;
         count_r <= count_nxt;
         flag_r <= flag_nxt;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         presc_r <= pmt_pkg::PRESC_ZERO;
      end else if (wr_lo || !run || trig_hit) begin
         presc_r <= pmt_pkg::PRESC_ZERO;
      end else if (active && raw_tick) begin
         presc_r <= presc_nxt;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         period_r <= pmt_pkg::PERIOD_RESET;
      end else if (wr_plo) begin
         period_r[7:0] <= i_wr_data;
      end else if (wr_phi) begin
         period_r[15:8] <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         hi_buf_r <= pmt_pkg::BYTE_ZERO;
      end else if (rd_lo) begin
         hi_buf_r <= count_r[15:8];
      end else if (wr_buf) begin
         hi_buf_r <= i_wr_data;
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_rd_data <= pmt_pkg::BYTE_ZERO;
         o_match_event <= 1'b0;
         o_run <= 1'b0;
      end else begin
         o_rd_data <= i_rd ? rd_mux : pmt_pkg::BYTE_ZERO;
         o_match_event <= match_hit;
         o_run <= ctl_nxt[pmt_pkg::CTL_RUN];
      end
   end

   assign o_match_flag = flag_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   wire quiet = !wr_lo && !trig_hit;

   property p_halt_holds;
      @(posedge i_clk_sys) disable iff (i_rst)
      (!run && quiet) |=> (count_r == $past(count_r));
   endproperty
   a_halt_holds: assert property (p_halt_holds) else $error("count moved while halted");

   property p_sleep_stops;
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_sleep && !sleep_en && quiet) |=> $stable(count_r);
   endproperty
   a_sleep_stops: assert property (p_sleep_stops) else $error("count moved in sleep");

   property p_trig_blocked;
      @(posedge i_clk_sys) disable iff (i_rst)
      (i_trig_reset && trig_dis && !wr_lo && !count_tick) |=> (count_r == $past(count_r));
   endproperty
   a_trig_blocked: assert property (p_trig_blocked) else $error("disabled trigger reset count");

   property p_match_clears;
      @(posedge i_clk_sys) disable iff (i_rst)
      (count_tick && at_period && quiet) |=> (count_r == pmt_pkg::COUNT_ZERO) && flag_r;
   endproperty
   a_match_clears: assert property (p_match_clears) else $error("match did not clear and flag");

   property p_single_stops;
      @(posedge i_clk_sys) disable iff (i_rst)
      (match_hit && single && !wr_ctl && !trig_wake) |=> !run ##1 !o_match_event;
   endproperty
   a_single_stops: assert property (p_single_stops) else $error("single-shot kept running");

   property p_cont_runs;
      @(posedge i_clk_sys) disable iff (i_rst)
      (count_tick && at_max && !single && quiet && !wr_ctl) |=> run && flag_r && (count_r == pmt_pkg::COUNT_ZERO);
   endproperty
   a_cont_runs: assert property (p_cont_runs) else $error("rollover mishandled");

   sequence s_low_read;
      rd_lo;
   endsequence

   sequence s_buf_loaded;
      (hi_buf_r == $past(count_r[15:8])) && (o_rd_data == $past(count_r[7:0]));
   endsequence

   property p_low_read;
      @(posedge i_clk_sys) disable iff (i_rst)
      s_low_read |=> s_buf_loaded;
   endproperty
   a_low_read: assert property (p_low_read) else $error("low read did not load buffer");

   property p_presc_clear;
      @(posedge i_clk_sys) disable iff (i_rst)
      !run |=> (presc_r == pmt_pkg::PRESC_ZERO);
   endproperty
   a_presc_clear: assert property (p_presc_clear) else $error("prescaler not cleared");

   property p_presc_bound;
      @(posedge i_clk_sys) disable iff (i_rst)
      (active && raw_tick && !wr_lo && !trig_hit && !wr_ctl) |=> (presc_r <= presc_lim);
   endproperty
   a_presc_bound: assert property (p_presc_bound) else $error("prescaler past limit");

   property p_flag_sticky;
      @(posedge i_clk_sys) disable iff (i_rst)
      (flag_r && !flag_clr) |=> flag_r;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped on its own");

   property p_match_event;
      @(posedge i_clk_sys) disable iff (i_rst)
      match_hit |=> o_match_event && flag_r;
   endproperty
   a_match_event: assert property (p_match_event) else $error("match gave no event or flag");

   property p_src_internal;
      @(posedge i_clk_sys) disable iff (i_rst)
      (run && !src_ext && !tick_bus.phase_one) |-> !count_tick;
   endproperty
   a_src_internal: assert property (p_src_internal) else $error("internal source counted off phase one");

   property p_trig_wake;
      @(posedge i_clk_sys) disable iff (i_rst)
      (trig_wake && !wr_ctl && !wr_lo) |=> run && (count_r == pmt_pkg::COUNT_ZERO);
   endproperty
   a_trig_wake: assert property (p_trig_wake) else $error("trigger did not wake single-shot");

endmodule : pmt_timer16
`default_nettype wire

// File: pmt_pin_src.sv
// Purpose: Pulse source standing in for whatever drives the external count pin
// Assumes: Bench system clock; one burst per request
// Notes:   Pin rests low between bursts, as a real source would stand still
`timescale 1ns/10ps
`default_nettype none
module pmt_pin_src (
   // Clock
   input wire logic i_clk_sys,
   // Command
   input wire logic i_go,
   input wire logic [7:0] i_n,
   // Pin
   output logic o_pin,
   output logic o_busy
);
   // Four clocks per level keeps each level longer than half an instruction cycle
   localparam int HALF = 4;
   initial begin
      o_pin = 1'b0;
      o_busy = 1'b0;
   end
   always @(posedge i_clk_sys) begin
      if (i_go && !o_busy) begin
         o_busy <= 1'b1;
         for (int k = 0; k < int'(i_n); k++) begin
            o_pin <= 1'b1;
            repeat (HALF) @(posedge i_clk_sys);
            o_pin <= 1'b0;
            repeat (HALF) @(posedge i_clk_sys);
         end
         o_busy <= 1'b0;
      end
   end
endmodule : pmt_pin_src
`default_nettype wire

// File: testbench.sv
// Purpose: Self-checking bench for the period match timer
// Assumes: Map 0 ctl, 1 count low, 2 high buffer, 3/4 period, 5 status
// Notes:   Second instance is the variant without the trigger disable bit
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic i_clk_sys = 1'b0;
   logic i_rst = 1'b1;
   logic [2:0] i_addr = 3'h0;
   logic [7:0] i_wr_data = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_sleep = 1'b0;
   logic i_trig_reset = 1'b0;
   logic go = 1'b0;
   logic [7:0] n_pulse = 8'h00;
   logic [7:0] rd_data;
   logic [7:0] rd_small;
   logic [7:0] d;
   logic [7:0] ds;
   logic flag;
   logic ev;
   logic run;
   wire logic pin;
   wire logic busy;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   int n;
   always #25 i_clk_sys = ~i_clk_sys;
   pmt_timer16 pmt_timer16_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
      .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(rd_data), .i_ext_count_pin(pin),
      .i_sleep(i_sleep), .i_trig_reset(i_trig_reset), .o_match_flag(flag), .o_match_event(ev), .o_run(run));
   pmt_timer16 #(.HAS_TRIG_DISABLE(1'b0)) pmt_timer16_inst_b (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(rd_small),
      .i_ext_count_pin(pin), .i_sleep(i_sleep), .i_trig_reset(i_trig_reset), .o_match_flag(),
      .o_match_event(), .o_run());
   pmt_pin_src pmt_pin_src_inst (.i_clk_sys(i_clk_sys), .i_go(go), .i_n(n_pulse), .o_pin(pin), .o_busy(busy));
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic close_out;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_wr_data <= v;
      i_wr <= 1'b1;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a);
      @(posedge i_clk_sys);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      @(negedge i_clk_sys);
      d = rd_data;
      ds = rd_small;
   endtask : rd
   task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
      rd(a);
      chk(d, e);
   endtask : rdchk
   task automatic wcnt(input logic [15:0] v);
      wr(3'h2, v[15:8]);
      wr(3'h1, v[7:0]);
   endtask : wcnt
   // Cycles from the call up to the next match pulse, bounded
   task automatic wait_ev;
      n = 0;
      do begin
         @(negedge i_clk_sys);
         n++;
      end while (ev !== 1'b1 && n < 2000);
   endtask : wait_ev
   task automatic pulses(input logic [7:0] k);
      int t;
      t = 0;
      @(posedge i_clk_sys);
      n_pulse <= k;
      go <= 1'b1;
      @(posedge i_clk_sys);
      go <= 1'b0;
      @(negedge i_clk_sys);
      while (busy === 1'b1 && t < 500) begin
         @(negedge i_clk_sys);
         t++;
      end
      // Let the last edge pass the synchroniser and reach phase one
      repeat (12) @(posedge i_clk_sys);
   endtask : pulses
   task automatic trig;
      @(posedge i_clk_sys);
      i_trig_reset <= 1'b1;
      @(posedge i_clk_sys);
      i_trig_reset <= 1'b0;
   endtask : trig
   task automatic tdone(input string s);
      $display("test %s done", s);
   endtask : tdone
   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         close_out();
      end
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      rdchk(3'h0, pmt_pkg::CTL_RESET);
      rdchk(3'h3, 8'hFF);
      rdchk(3'h4, 8'hFF);
      rdchk(3'h5, 8'h00);
      rdchk(3'h7, 8'h00);
      tdone("reset");
      wcnt(16'h1234);
      rdchk(3'h1, 8'h34);
      rdchk(3'h2, 8'h12);
      wr(3'h2, 8'h56);
      rdchk(3'h1, 8'h34);
      rdchk(3'h2, 8'h12);
      tdone("pairing");
      wr(3'h3, 8'h02);
      wr(3'h4, 8'h00);
      wcnt(16'h0000);
      wr(3'h0, 8'h01);
      wait_ev();
      chk(n <= 20, 1'b1);
      @(negedge i_clk_sys);
      chk(flag, 1'b1);
      wr(3'h0, 8'h00);
      @(negedge i_clk_sys);
      chk(run, 1'b0);
      repeat (30) @(posedge i_clk_sys);
      @(negedge i_clk_sys);
      chk(flag, 1'b1);
      wr(3'h5, 8'h01);
      @(negedge i_clk_sys);
      chk(flag, 1'b0);
      rd(3'h1);
      chk(d <= 8'h02, 1'b1);
      n = d;
      repeat (40) @(posedge i_clk_sys);
      rdchk(3'h1, n[7:0]);
      tdone("match");
      wr(3'h3, 8'h03);
      for (int ps = 0; ps < 4; ps++) begin
         wr(3'h0, {3'h0, ps[1:0], 3'h1});
         wait_ev();
         wait_ev();
         chk(n, 16 << ps);
      end
      wr(3'h0, 8'h01);
      wr(3'h3, 8'h07);
      wait_ev();
      wait_ev();
      chk(n, 32);
      wr(3'h0, 8'h00);
      wr(3'h5, 8'h01);
      tdone("prescale");
      wr(3'h3, 8'h00);
      wcnt(16'h0000);
      wr(3'h0, 8'h19);
      wait_ev();
      // Leave a part-filled prescaler behind before the count write
      repeat (12) @(posedge i_clk_sys);
      wcnt(16'h0000);
      wait_ev();
      chk(n >= 31 && n <= 34, 1'b1);
      wr(3'h0, 8'h00);
      wr(3'h5, 8'h01);
      tdone("prescaler clear");
      wr(3'h3, 8'h02);
      wcnt(16'h0000);
      wr(3'h0, 8'h21);
      wait_ev();
      repeat (2) @(negedge i_clk_sys);
      chk(run, 1'b0);
      rdchk(3'h0, 8'h20);
      rdchk(3'h1, 8'h00);
      tdone("single");
      wr(3'h3, 8'hFF);
      wr(3'h4, 8'hFF);
      wcnt(16'h0000);
      wr(3'h0, 8'h03);
      pulses(8'h05);
      rdchk(3'h1, 8'h05);
      wr(3'h0, 8'h07);
      pulses(8'h03);
      rdchk(3'h1, 8'h08);
      wr(3'h0, 8'h04);
      wcnt(16'h0000);
      wr(3'h0, 8'h05);
      repeat (80) @(posedge i_clk_sys);
      wr(3'h0, 8'h04);
      rd(3'h1);
      chk(d >= 8'd19 && d <= 8'd22, 1'b1);
      tdone("source");
      wcnt(16'h0000);
      i_sleep <= 1'b1;
      wr(3'h0, 8'h03);
      pulses(8'h03);
      rdchk(3'h1, 8'h00);
      wr(3'h0, 8'h83);
      pulses(8'h02);
      rdchk(3'h1, 8'h00);
      // Software side of the sleep rule: bypass set together with sleep run
      wr(3'h0, 8'h87);
      pulses(8'h03);
      rdchk(3'h1, 8'h03);
      i_sleep <= 1'b0;
      wr(3'h0, 8'h00);
      tdone("sleep");
      wcnt(16'h1234);
      trig();
      rdchk(3'h1, 8'h00);
      rdchk(3'h2, 8'h00);
      wr(3'h0, pmt_pkg::CTL_TRIG_DIS_MASK);
      wcnt(16'h1234);
      trig();
      rdchk(3'h1, 8'h34);
      chk(ds, 8'h00);
      rd(3'h0);
      chk(ds, 8'h00);
      chk(d, 8'h40);
      tdone("trigger");
      wr(3'h0, 8'h20);
      trig();
      rdchk(3'h0, 8'h21);
      wr(3'h0, 8'h00);
      tdone("wake");
      close_out();
   end
endmodule : testbench
`default_nettype wire
